/* File: src/dcsv_status_view.v */
// Top of the two-channel status view with its bus slave and interrupt.
// Overview of operation
// - Raw transfer-done flag per channel, bits 0-1.
// - Raw error flag per channel, bits 0-1.
// - Enable status bit per channel, bits 0-1.
// - Enable bit clears when transfer count reaches zero.
`include "dcsv_map.vh"
module dcsv_status_view (
    input  wire        core_clk,
    input  wire        rst_b,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire [1:0]  doneEvent,
    input  wire [1:0]  doneClear,
    input  wire [1:0]  errorEvent,
    input  wire [1:0]  errorClear,
    input  wire [1:0]  enableSet,
    input  wire [1:0]  countZero,
    output reg         irq
);
    // ======================================================================
    // Channel flags
    wire [1:0] rawDone;
    wire [1:0] rawError;
    wire [1:0] active;
    wire [1:0] idlePulse;

    dcsv_channel_flags uCh0 (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .doneEvent  (doneEvent[`DCSV_CH0_BIT]),
        .doneClear  (doneClear[`DCSV_CH0_BIT]),
        .errorEvent (errorEvent[`DCSV_CH0_BIT]),
        .errorClear (errorClear[`DCSV_CH0_BIT]),
        .enableSet  (enableSet[`DCSV_CH0_BIT]),
        .countZero  (countZero[`DCSV_CH0_BIT]),
        .rawDone    (rawDone[`DCSV_CH0_BIT]),
        .rawError   (rawError[`DCSV_CH0_BIT]),
        .active     (active[`DCSV_CH0_BIT]),
        .idlePulse  (idlePulse[`DCSV_CH0_BIT])
    );

    dcsv_channel_flags uCh1 (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .doneEvent  (doneEvent[`DCSV_CH1_BIT]),
        .doneClear  (doneClear[`DCSV_CH1_BIT]),
        .errorEvent (errorEvent[`DCSV_CH1_BIT]),
        .errorClear (errorClear[`DCSV_CH1_BIT]),
        .enableSet  (enableSet[`DCSV_CH1_BIT]),
        .countZero  (countZero[`DCSV_CH1_BIT]),
        .rawDone    (rawDone[`DCSV_CH1_BIT]),
        .rawError   (rawError[`DCSV_CH1_BIT]),
        .active     (active[`DCSV_CH1_BIT]),
        .idlePulse  (idlePulse[`DCSV_CH1_BIT])
    );

    // ======================================================================
    // Address phase capture
    reg        dataPhase;
    reg        dataWrite;
    reg [11:0] dataAddr;
    wire       addrValid = hsel & htrans[1] & hready;

    function hitOffset;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            hitOffset = (addr == ofs);
        end
    endfunction

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dataPhase <= 1'b0;
            dataWrite <= 1'b0;
            dataAddr  <= 12'h000;
        end else if (hready) begin
            dataPhase <= addrValid;
            dataWrite <= hwrite;
            dataAddr  <= haddr[11:0];
        end
    end

    // ======================================================================
    // Interrupt status and mask
    // Events are latched here rather than reading the raw flags, so that a
    // short-lived raw request is still seen by the interrupt line.
    reg  [5:0] irqStatus;
    reg  [5:0] irqMask;
    wire [5:0] irqEvents = {idlePulse, errorEvent, doneEvent};
    wire       wrStatus  = dataPhase & dataWrite & hitOffset(dataAddr, `DCSV_IRQ_STATUS_OFS);
    wire       wrMask    = dataPhase & dataWrite & hitOffset(dataAddr, `DCSV_IRQ_MASK_OFS);
    wire [5:0] next_irqStatus = irqEvents |
                                (irqStatus & ~(wrStatus ? hwdata[5:0] : 6'h00));

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqStatus <= `DCSV_IRQ_RST;
            irqMask   <= `DCSV_IRQ_RST;
            irq       <= 1'b0;
        end else begin
            irqStatus <= next_irqStatus;
            if (wrMask)
                irqMask <= hwdata[5:0];
            irq <= |(next_irqStatus & (wrMask ? hwdata[5:0] : irqMask));
        end
    end

    // ======================================================================
    // Read data; writes to the three status registers have no effect.
    function [31:0] padFlags;
        input [1:0] flags;
        begin
            padFlags = {30'h0000_0000, flags};
        end
    endfunction

    reg [31:0] next_hrdata;
    always @* begin
        if (!addrValid || hwrite)
            next_hrdata = `DCSV_RDATA_RST;
        else if (hitOffset(haddr[11:0], `DCSV_RAW_DONE_OFS))
            next_hrdata = padFlags(rawDone);
        else if (hitOffset(haddr[11:0], `DCSV_RAW_ERR_OFS))
            next_hrdata = padFlags(rawError);
        else if (hitOffset(haddr[11:0], `DCSV_CH_ACTIVE_OFS))
            next_hrdata = padFlags(active);
        else if (hitOffset(haddr[11:0], `DCSV_IRQ_STATUS_OFS))
            next_hrdata = {26'h000_0000, irqStatus};
        else if (hitOffset(haddr[11:0], `DCSV_IRQ_MASK_OFS))
            next_hrdata = {26'h000_0000, irqMask};
        else
            next_hrdata = `DCSV_RDATA_RST;
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata    <= `DCSV_RDATA_RST;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready)
                hrdata <= next_hrdata;
        end
    end
endmodule // dcsv_status_view

/* File: src/dcsv_map.vh */
// Register offsets, field positions and reset values of the channel status view.
`ifndef DCSV_MAP_VH
`define DCSV_MAP_VH
// ==========================================================================
// Register byte offsets
`define DCSV_RAW_DONE_OFS     12'h000
`define DCSV_RAW_ERR_OFS      12'h004
`define DCSV_CH_ACTIVE_OFS    12'h008
`define DCSV_IRQ_STATUS_OFS   12'h00c
`define DCSV_IRQ_MASK_OFS     12'h010
// ==========================================================================
// Field positions
`define DCSV_CH0_BIT          0
`define DCSV_CH1_BIT          1
`define DCSV_IRQ_DONE_LSB     0
`define DCSV_IRQ_ERR_LSB      2
`define DCSV_IRQ_IDLE_LSB     4
`define DCSV_IRQ_WIDTH        6
// ==========================================================================
// Reset values
`define DCSV_FLAGS_RST        2'h0
`define DCSV_IRQ_RST          6'h00
`define DCSV_RDATA_RST        32'h0000_0000
`endif

/* File: src/dcsv_channel_flags.v */
// Per-channel raw request and enable flags of the channel status view.
`include "dcsv_map.vh"
module dcsv_channel_flags (
    input  wire       core_clk,
    input  wire       rst_b,
    input  wire       doneEvent,
    input  wire       doneClear,
    input  wire       errorEvent,
    input  wire       errorClear,
    input  wire       enableSet,
    input  wire       countZero,
    output reg        rawDone,
    output reg        rawError,
    output reg        active,
    output wire       idlePulse
);
    // ======================================================================
    // Flags
    // Set wins over clear for the done and error flags so a request arriving with its clear is kept.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rawDone  <= 1'b0;
            rawError <= 1'b0;
            active   <= 1'b0;
        end else begin
            if (doneEvent)
                rawDone <= 1'b1;
            else if (doneClear)
                rawDone <= 1'b0;
            if (errorEvent)
                rawError <= 1'b1;
            else if (errorClear)
                rawError <= 1'b0;
            // A zero count wins over a new enable.
            // A channel with nothing left to move reads as disabled from the next edge on.
            if (countZero)
                active <= 1'b0;
            else if (enableSet)
                active <= 1'b1;
        end
    end

    assign idlePulse = active & countZero;
endmodule // dcsv_channel_flags

/* File: verification/dcsv_status_view_asserts.sv */
// Port checks of the channel status view.
module dcsv_status_view_asserts (
    input logic        core_clk,
    input logic        rst_b,
    input logic        hsel,
    input logic [31:0] haddr,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic        hready,
    input logic [31:0] hrdata,
    input logic [1:0]  doneEvent,
    input logic [1:0]  errorEvent,
    input logic [1:0]  enableSet,
    input logic [1:0]  countZero
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ==================================================
    // Reads are judged one edge after the address phase.
    sequence rd(a);
        hsel && htrans[1] && hready && !hwrite && haddr[11:0] == a;
    endsequence
    a_done_raw: assert property (doneEvent == 2'h3 ##1 rd(12'h000)
        |=> hrdata[1:0] == 2'h3) else $error("raw done not set");
    a_error_raw: assert property (errorEvent[1] ##1 rd(12'h004)
        |=> hrdata[1]) else $error("raw error not set");
    a_enable_set: assert property (enableSet == 2'h3 && !countZero ##1 rd(12'h008)
        |=> hrdata[1:0] == 2'h3) else $error("enable not set");
    a_enable_clear: assert property (countZero == 2'h3 ##1 rd(12'h008)
        |=> hrdata[1:0] == 2'h0) else $error("enable not cleared");
    a_upper_zero: assert property (hsel && htrans[1] && hready && !hwrite
        && haddr[11:0] < 12'h00c |=> hrdata[31:2] == 30'h0) else $error("upper bits set");
endmodule // dcsv_status_view_asserts
bind dcsv_status_view dcsv_status_view_asserts u_chk (.core_clk, .rst_b, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hrdata, .doneEvent, .errorEvent, .enableSet, .countZero);

/* File: verification/dcsv_status_view_bench.sv */
// Directed bench for the channel status view.
module dcsv_status_view_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = '0, rst_b = '0, hsel = '0, hwrite = '0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [1:0]  htrans = '0, doneEvent = '0, doneClear = '0, errorEvent = '0;
    logic [1:0]  errorClear = '0, enableSet = '0, countZero = '0;
    logic        hreadyout, hresp, irq;
    int          bad_count = 0, n_compared = 0, cyc = 0;
    dcsv_status_view dut (.core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .doneEvent, .doneClear, .errorEvent, .errorClear, .enableSet, .countZero, .irq);
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    // The whole run needs about 60 cycles; a hang is cut short here at cycle 3000.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            report_and_stop;
        end
    end
    // ==================================================
    // Bus and side-input tasks.
    task automatic chk(input [31:0] g, e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic xfer(input w, input [31:0] a, d);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= a;
        do @(posedge core_clk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'h1);
        r = hrdata;
    endtask
    task automatic rd(input [31:0] a, e);
        xfer(1'h0, a, '0);
        chk(r, e);
        chk(hresp, '0);
    endtask
    // One-cycle pulse; the read that follows starts right after it.
    task automatic side(input [11:0] v);
        @(posedge core_clk);
        {doneEvent, doneClear, errorEvent, errorClear, enableSet, countZero} <= v;
        @(posedge core_clk);
        {doneEvent, doneClear, errorEvent, errorClear, enableSet, countZero} <= '0;
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==================================================
    // Test sequence.
    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'h1;
        for (int i = 0; i < 6; i++) rd(i * 4, '0);
        $display("test reset done");
        side(12'hc00);
        rd(32'h0, 32'h3);
        side(12'h100);
        rd(32'h0, 32'h2);
        xfer(1'h1, 32'h0, '1);
        rd(32'h0, 32'h2);
        side(12'h080);
        rd(32'h4, 32'h2);
        side(12'h00c);
        rd(32'h8, 32'h3);
        side(12'h001);
        rd(32'h8, 32'h2);
        side(12'h00f);
        rd(32'h8, 32'h0);
        $display("test flags done");
        rd(32'hc, 32'h3b);
        chk(irq, 32'h0);
        xfer(1'h1, 32'h10, 32'h1);
        @(posedge core_clk);
        chk(irq, 32'h1);
        xfer(1'h1, 32'hc, 32'h1);
        @(posedge core_clk);
        chk(irq, 32'h0);
        rd(32'hc, 32'h3a);
        $display("test interrupt done");
        report_and_stop;
    end
endmodule // dcsv_status_view_bench
